// ---- bench/coax_port_mode_page_control_tb.sv ----
module coax_port_mode_page_control_tb
	import sdimc_pkg::*;
;
	timeunit 1ns/1ps;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_wdata = 8'h00;
	logic [3:0] cfg = 4'h8;
	logic man = 1'b0;
	logic present = 1'b0;
	logic [1:0] rate = 2'h0;
	logic done, refused, locked, drv, hen, sen, cdrv, hfc, byp, eye, spi;
	logic [2:0] pg;
	logic [3:0] bst;
	logic [7:0] rdata, rnd;
	logic [9:0] exp_q[$];
	logic [9:0] e_m;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	sdimc_if bus_if();
	sdimc_host sdimc_host_i(.clk_sys, .rstn, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata,
		.cfg_driver_mode(cfg[0]), .cfg_host_out_off(cfg[1]), .cfg_loop_out_off(cfg[2]), .cfg_spi(cfg[3]),
		.cdr_locked(locked), .manual_mode(man), .cmd_done(done), .cmd_refused(refused), .cmd_rdata(rdata),
		.bus(bus_if));
	sdimc_dev #(.ADAPT_CYCLES(4)) sdimc_dev_i(.clk_sys, .rstn, .input_rate(rate), .input_present(present),
		.bus(bus_if), .page(pg), .driver_mode(drv), .host_output_en(hen), .second_coax_output_en(sen),
		.coax_port_drive(cdrv), .host_output_from_coax(hfc), .cdr_locked(locked), .reclock_bypass(byp),
		.eye_monitor_on(eye), .boost(bst), .spi_mode(spi));
	sdimc_assertions sdimc_assertions_i(.clk_sys, .rstn, .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .if_select_float(bus_if.if_select_float));
	always #12.5 clk_sys = ~clk_sys;
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Reads wait out the full answer latency, so one fixed spacing serves all commands.
	task automatic cmd(logic w, logic [7:0] a, logic [7:0] d, logic [9:0] e);
		exp_q.push_back(e);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d, logic f = 1'b0);
		cmd(1'b1, a, d, {1'b0, f, 8'h00});
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		cmd(1'b0, a, 8'h00, {2'b10, e});
	endtask
	task automatic pins(logic [3:0] c, logic m);
		logic d;
		d = c[0] | m;
		cfg <= c;
		repeat (6) @(posedge clk_sys);
		chk("coax_drive", 8'(d), 8'(cdrv));
		chk("driver_mode", 8'(d), 8'(drv));
		chk("from_coax", 8'(!d), 8'(hfc));
		chk("host_en", 8'(!d || !c[1]), 8'(hen));
		chk("loop_en", 8'(!c[2]), 8'(sen));
	endtask
	task automatic wait_lock(logic l);
		for (int k = 0; k < 60 && locked !== l; k++)
			@(posedge clk_sys);
		repeat (20) @(posedge clk_sys);
		chk("locked", 8'(l), 8'(locked));
	endtask
	always @(posedge clk_sys) begin
		if (rstn && (done === 1'b1 || refused === 1'b1)) begin
			e_m = exp_q.pop_front();
			chk("refused", 8'(e_m[8]), 8'(refused));
			// Read data stands from the done pulse until the next read.
			if (e_m[9]) begin
				chk("rdata", e_m[7:0], rdata);
			end
		end
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h919E));
		rnd = 8'($urandom() % 16);
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk("page", 8'(SDIMC_PAGE_GLOBAL), 8'(pg));
		chk("spi", 8'h01, 8'(spi));
		rd(SDIMC_PAGE_ADDR, 8'h00);
		wr(SDIMC_PAGE_ADDR, 8'h04);
		rd(SDIMC_PAGE_ADDR, 8'h04);
		rd(SDIMC_EYE_MON_ADDR, SDIMC_EYE_MON_RST);
		wr(SDIMC_PAGE_ADDR, 8'h05);
		rd(SDIMC_EYE_MON_ADDR, 8'h00);
		wr(SDIMC_BOOST_ADDR, rnd);
		rd(SDIMC_BOOST_ADDR, rnd);
		wr(SDIMC_PAGE_ADDR, 8'h00);
		for (int i = 0; i < 8; i++)
			pins(4'(8 + i), 1'b0);
		wr(SDIMC_MODE_ADDR, 8'h01);
		pins(4'h8, 1'b1);
		wr(SDIMC_MODE_ADDR, 8'h00);
		pins(4'h9, 1'b0);
		wr(SDIMC_PAGE_ADDR, 8'h04);
		wr(SDIMC_EYE_MON_ADDR, 8'h00, 1'b1);
		rd(SDIMC_EYE_MON_ADDR, SDIMC_EYE_MON_RST);
		present <= 1'b1;
		wait_lock(1'b1);
		wr(SDIMC_EYE_MON_ADDR, 8'h00);
		chk("eye_on", 8'h00, 8'(eye));
		chk("held_lock", 8'h01, 8'(locked));
		wr(SDIMC_PAGE_ADDR, 8'h00);
		wr(SDIMC_MODE_ADDR, 8'h02);
		man <= 1'b1;
		rate <= 2'h3;
		wait_lock(1'b0);
		wr(SDIMC_PAGE_ADDR, 8'h04);
		wr(SDIMC_EYE_MON_ADDR, 8'h00);
		for (int r = 3; r >= 0; r--) begin
			rate <= 2'(r);
			wait_lock(r != 3);
			chk("bypass", 8'(r == 3), 8'(byp));
		end
		wr(SDIMC_PAGE_ADDR, 8'h00);
		rd(SDIMC_STATUS_ADDR, 8'h0F);
		chk("boost", 8'(rnd[3:0]), 8'(bst));
		// Second power-up with the strap tied low: the session must come up in the other bus mode.
		cfg <= 4'h0;
		rstn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk("page", 8'(SDIMC_PAGE_GLOBAL), 8'(pg));
		chk("spi", 8'h00, 8'(spi));
		rd(SDIMC_STATUS_ADDR, 8'h09);
		cfg <= 4'h8;
		repeat (8) @(posedge clk_sys);
		chk("spi_held", 8'h00, 8'(spi));
		give_verdict();
	end
endmodule

// ---- bench/sdimc_assertions.sv ----
module sdimc_assertions
	import sdimc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic if_select_float
);
	timeunit 1ns/1ps;
	// Shadow copies rebuilt from bus writes, so reads can be judged without the device's state.
	logic [2:0] pg_reg;
	logic [7:0] eye_reg;
	logic pg_set_reg;
	wire logic pg_wr = wr_en && addr == SDIMC_PAGE_ADDR;
	wire logic eq_pg = pg_reg == SDIMC_PAGE_EQCDR;
	wire logic rd_pg = rd_en && addr == SDIMC_PAGE_ADDR;
	wire logic rd_eye = rd_en && addr == SDIMC_EYE_MON_ADDR;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pg_reg <= SDIMC_PAGE_GLOBAL;
			eye_reg <= SDIMC_EYE_MON_RST;
			pg_set_reg <= 1'b0;
		end else begin
			pg_set_reg <= pg_set_reg | pg_wr;
			if (pg_wr)
				pg_reg <= wdata[2:0];
			if (wr_en && addr == SDIMC_EYE_MON_ADDR && eq_pg)
				eye_reg <= wdata;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	AST_PAGE_DEFAULT: assert property (rd_pg && !pg_set_reg |=> rdata[2:0] == SDIMC_PAGE_GLOBAL)
		else $error("page not global after reset");
	AST_PAGE_READ: assert property (rd_pg |=> rdata[2:0] == pg_reg)
		else $error("page select readback wrong");
	AST_EYE_READ: assert property (rd_eye && eq_pg |=> rdata[7] == eye_reg[7])
		else $error("eye monitor control readback wrong");
	AST_OFF_PAGE: assert property (rd_eye && pg_reg == SDIMC_PAGE_IOCFG |=> rdata == 8'h00)
		else $error("equalizer page register seen on io page");
	AST_READ_PULSE: assert property (rd_en |=> !rd_en)
		else $error("read strobe longer than one cycle");
	AST_RDATA_HOLD: assert property (!rd_en |=> $stable(rdata))
		else $error("read data changed without a read");
	AST_NO_OVERLAP: assert property (wr_en |-> !rd_en)
		else $error("read and write strobes together");
	AST_IF_MODE: assert property (rd_en && addr == SDIMC_STATUS_ADDR ##1 rdata[0] |-> rdata[1] == if_select_float)
		else $error("interface mode differs from strap");
endmodule

// ---- hdl/sdimc_dev.sv ----
module sdimc_dev
	import sdimc_pkg::*;
#(
	parameter int ADAPT_CYCLES = SDIMC_ADAPT_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [1:0] input_rate,
	input wire logic input_present,
	sdimc_if.dev bus,
	output logic [2:0] page,
	output logic driver_mode,
	output logic host_output_en,
	output logic second_coax_output_en,
	output logic coax_port_drive,
	output logic host_output_from_coax,
	output logic cdr_locked,
	output logic reclock_bypass,
	output logic eye_monitor_on,
	output logic [3:0] boost,
	output logic spi_mode
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// The chain resets to the pins' idle levels (strap floating, selects low), so no false
	// pin change is seen while it fills after reset.
	logic [3:0] pin_s1_reg;
	logic [3:0] pin_s2_reg;
	logic [3:0] pin_s3_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_s1_reg <= 4'h8;
			pin_s2_reg <= 4'h8;
			pin_s3_reg <= 4'h8;
		end else begin
			pin_s1_reg <= {bus.if_select_float, bus.loop_output_select_pin,
				bus.host_output_select_pin, bus.direction_select_pin};
			pin_s2_reg <= pin_s1_reg;
			// The third stage serves only the strap stability check, so the first stage feeds nothing else.
			pin_s3_reg <= pin_s2_reg;
		end
	end
	wire dir_pin = pin_s2_reg[0];
	wire ho_pin = pin_s2_reg[1];
	wire lo_pin = pin_s2_reg[2];
	wire ifsel = pin_s2_reg[3];
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [2:0] page_reg;
	logic [7:0] eye_reg, mode_reg, boost_reg, rdata_reg;
	logic strap_done_reg, spi_reg;
	wire wr_page = bus.wr_en && bus.addr == SDIMC_PAGE_ADDR;
	wire on_eq = page_reg == SDIMC_PAGE_EQCDR;
	wire on_io = page_reg == SDIMC_PAGE_IOCFG;
	wire wr_eye = bus.wr_en && on_eq && bus.addr == SDIMC_EYE_MON_ADDR;
	wire wr_mode = bus.wr_en && page_reg == SDIMC_PAGE_GLOBAL && bus.addr == SDIMC_MODE_ADDR;
	wire wr_boost = bus.wr_en && on_io && bus.addr == SDIMC_BOOST_ADDR;
	// Register bit 0 overrides pin to driver mode, bit 1 selects manual boost.
	wire drv_next = dir_pin || mode_reg[0];
	wire manual = mode_reg[1];
	logic [7:0] status_w;
	logic [7:0] rd_next;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			page_reg <= SDIMC_PAGE_GLOBAL;
			eye_reg <= SDIMC_EYE_MON_RST;
			mode_reg <= SDIMC_MODE_RST;
			boost_reg <= SDIMC_BOOST_RST;
			rdata_reg <= 8'h00;
		end else begin
			if (wr_page) begin
				page_reg <= bus.wdata[2:0];
			end
			if (wr_eye) begin
				eye_reg <= bus.wdata;
			end
			if (wr_mode) begin
				mode_reg <= bus.wdata;
			end
			if (wr_boost) begin
				boost_reg <= bus.wdata;
			end
			if (bus.rd_en) begin
				rdata_reg <= rd_next;
			end
		end
	end
	// ------------------------------------------------------------
	// Power-up strap of the register interface
	// ------------------------------------------------------------
	// The strap is taken only once the host's pin level has reached the second stage, never
	// the reset value still travelling down the chain. Later pin changes wait for the next
	// reset, since a bus mode swap in mid-session would strand the host.
	logic [2:0] strap_wait_reg;
	wire strap_filled = strap_wait_reg == 3'(SDIMC_STRAP_SETTLE);
	wire strap_take = !strap_done_reg && strap_filled && pin_s2_reg == pin_s3_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strap_wait_reg <= 3'h0;
			strap_done_reg <= 1'b0;
			spi_reg <= 1'b1;
		end else begin
			if (!strap_filled) begin
				strap_wait_reg <= strap_wait_reg + 3'h1;
			end
			if (strap_take) begin
				strap_done_reg <= 1'b1;
				spi_reg <= ifsel;
			end
		end
	end
	assign bus.rdata = rdata_reg;
	// ------------------------------------------------------------
	// Clock recovery and adaptation
	// ------------------------------------------------------------
	sdimc_cdr_e st_reg;
	logic [7:0] cnt_reg;
	logic [3:0] auto_boost_reg;
	wire supported = sdimc_rate_e'(input_rate) != SDIMC_RATE_OTHER;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_reg <= SDIMC_ST_SEEK;
			cnt_reg <= 8'h00;
			auto_boost_reg <= 4'h0;
		end else begin
			unique case (st_reg)
				SDIMC_ST_SEEK: begin
					if (!input_present) begin
						cnt_reg <= 8'h00;
					end else if (!supported) begin
						st_reg <= SDIMC_ST_BYPASS;
					end else if (manual || cnt_reg == 8'(ADAPT_CYCLES - 1)) begin
						st_reg <= SDIMC_ST_LOCK;
					end else if (eye_reg[SDIMC_EYE_EN_BIT]) begin
						// Adaptive sweep steps boost while the eye monitor scores it.
						cnt_reg <= cnt_reg + 8'h01;
						auto_boost_reg <= auto_boost_reg + 4'h1;
					end
				end
				SDIMC_ST_LOCK: begin
					// Lock no longer leans on the eye monitor, so the host may switch it off here.
					if (!input_present || !supported) begin
						st_reg <= SDIMC_ST_SEEK;
						cnt_reg <= 8'h00;
					end
				end
				SDIMC_ST_BYPASS: begin
					// An unsupported rate passes through unretimed until a supported one returns or the input is lost.
					if (supported || !input_present) begin
						st_reg <= SDIMC_ST_SEEK;
					end
				end
				default: st_reg <= SDIMC_ST_SEEK;
			endcase
		end
	end
	// ------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------
	// The page register answers on every page, so the host can never lock itself out.
	wire rd_page_hit = bus.addr == SDIMC_PAGE_ADDR;
	wire rd_eye_hit = on_eq && bus.addr == SDIMC_EYE_MON_ADDR;
	wire rd_mode_hit = page_reg == SDIMC_PAGE_GLOBAL && bus.addr == SDIMC_MODE_ADDR;
	wire rd_status_hit = page_reg == SDIMC_PAGE_GLOBAL && bus.addr == SDIMC_STATUS_ADDR;
	wire rd_boost_hit = on_io && bus.addr == SDIMC_BOOST_ADDR;
	wire st_bypass = st_reg == SDIMC_ST_BYPASS;
	wire st_lock = st_reg == SDIMC_ST_LOCK;
	assign status_w = {3'h0, st_bypass, st_lock, drv_next, spi_reg, strap_done_reg};
	// Unmapped and off-page addresses read as zero.
	assign rd_next = rd_page_hit ? {5'h00, page_reg} :
		rd_eye_hit ? eye_reg :
		rd_mode_hit ? mode_reg :
		rd_status_hit ? status_w :
		rd_boost_hit ? boost_reg :
		8'h00;
	// ------------------------------------------------------------
	// Output steering
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			page <= SDIMC_PAGE_GLOBAL;
			driver_mode <= 1'b0;
			host_output_en <= 1'b1;
			second_coax_output_en <= 1'b0;
			coax_port_drive <= 1'b0;
			host_output_from_coax <= 1'b1;
			cdr_locked <= 1'b0;
			reclock_bypass <= 1'b0;
			eye_monitor_on <= 1'b1;
			boost <= 4'h0;
			spi_mode <= 1'b1;
		end else begin
			page <= page_reg;
			driver_mode <= drv_next;
			// The host output may be shut only in driver mode; in equalizer mode it carries the received video.
			host_output_en <= !drv_next || !ho_pin;
			second_coax_output_en <= !lo_pin;
			coax_port_drive <= drv_next;
			host_output_from_coax <= !drv_next;
			cdr_locked <= st_reg == SDIMC_ST_LOCK;
			reclock_bypass <= st_reg == SDIMC_ST_BYPASS;
			eye_monitor_on <= eye_reg[SDIMC_EYE_EN_BIT];
			// Adaptive boost serves the host input, which is only in use in driver mode.
			boost <= (drv_next && !manual) ? auto_boost_reg : boost_reg[3:0];
			spi_mode <= spi_reg;
		end
	end
endmodule

// ---- hdl/sdimc_host.sv ----
module sdimc_host
	import sdimc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cfg_driver_mode,
	input wire logic cfg_host_out_off,
	input wire logic cfg_loop_out_off,
	input wire logic cfg_spi,
	input wire logic cdr_locked,
	input wire logic manual_mode,
	output logic cmd_done,
	output logic cmd_refused,
	output logic [7:0] cmd_rdata,
	sdimc_if.host bus
);
	// ------------------------------------------------------------
	// Guard on eye monitor shut-off
	// ------------------------------------------------------------
	wire eye_off_wr = cmd_write && cmd_addr == SDIMC_EYE_MON_ADDR && !cmd_wdata[SDIMC_EYE_EN_BIT];
	wire refuse = cmd_valid && eye_off_wr && !cdr_locked && !manual_mode;
	wire issue = cmd_valid && !refuse;
	logic wr_reg, rd_reg, done_reg, ref_reg, rdp_reg;
	logic [7:0] addr_reg, wdata_reg, rdata_reg;
	logic dir_reg, ho_reg, lo_reg, spi_reg;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			rdp_reg <= 1'b0;
			done_reg <= 1'b0;
			ref_reg <= 1'b0;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			rdata_reg <= 8'h00;
			dir_reg <= 1'b0;
			ho_reg <= 1'b0;
			lo_reg <= 1'b0;
			spi_reg <= 1'b1;
		end else begin
			wr_reg <= issue && cmd_write;
			rd_reg <= issue && !cmd_write;
			rdp_reg <= rd_reg;
			done_reg <= (issue && cmd_write) || rdp_reg;
			ref_reg <= refuse;
			if (issue) begin
				addr_reg <= cmd_addr;
				wdata_reg <= cmd_wdata;
			end
			if (rdp_reg) begin
				rdata_reg <= bus.rdata;
			end
			dir_reg <= cfg_driver_mode;
			ho_reg <= cfg_host_out_off;
			lo_reg <= cfg_loop_out_off;
			spi_reg <= cfg_spi;
		end
	end
	assign bus.wr_en = wr_reg;
	assign bus.rd_en = rd_reg;
	assign bus.addr = addr_reg;
	assign bus.wdata = wdata_reg;
	assign bus.direction_select_pin = dir_reg;
	assign bus.host_output_select_pin = ho_reg;
	assign bus.loop_output_select_pin = lo_reg;
	assign bus.if_select_float = spi_reg;
	assign cmd_done = done_reg;
	assign cmd_refused = ref_reg;
	assign cmd_rdata = rdata_reg;
endmodule

// ---- hdl/sdimc_if.sv ----
interface sdimc_if;
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic direction_select_pin;
	logic host_output_select_pin;
	logic loop_output_select_pin;
	logic if_select_float;
	modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata,
		input direction_select_pin, input host_output_select_pin,
		input loop_output_select_pin, input if_select_float);
	modport host (output wr_en, output rd_en, output addr, output wdata, input rdata,
		output direction_select_pin, output host_output_select_pin,
		output loop_output_select_pin, output if_select_float);
endinterface

// ---- hdl/sdimc_pkg.sv ----
package sdimc_pkg;
	localparam logic [7:0] SDIMC_EYE_MON_ADDR = 8'h3E;
	localparam logic [7:0] SDIMC_PAGE_ADDR = 8'hFF;
	localparam logic [7:0] SDIMC_MODE_ADDR = 8'h10;
	localparam logic [7:0] SDIMC_BOOST_ADDR = 8'h11;
	localparam logic [7:0] SDIMC_STATUS_ADDR = 8'h12;
	localparam logic [2:0] SDIMC_PAGE_GLOBAL = 3'h0;
	localparam logic [2:0] SDIMC_PAGE_EQCDR = 3'h4;
	localparam logic [2:0] SDIMC_PAGE_IOCFG = 3'h5;
	localparam int SDIMC_EYE_EN_BIT = 7;
	localparam logic [7:0] SDIMC_EYE_MON_RST = 8'h80;
	localparam logic [7:0] SDIMC_MODE_RST = 8'h00;
	localparam logic [7:0] SDIMC_BOOST_RST = 8'h08;
	localparam int SDIMC_ADAPT_CYCLES = 16;
	localparam int SDIMC_STRAP_SETTLE = 3;
	typedef enum logic [1:0] {
		SDIMC_RATE_3G = 2'h0,
		SDIMC_RATE_HD = 2'h1,
		SDIMC_RATE_SD = 2'h2,
		SDIMC_RATE_OTHER = 2'h3
	} sdimc_rate_e;
	typedef enum logic [1:0] {
		SDIMC_ST_SEEK = 2'h0,
		SDIMC_ST_LOCK = 2'h1,
		SDIMC_ST_BYPASS = 2'h3
	} sdimc_cdr_e;
endpackage
